// ---- sfd_pkg.sv ----
package sfd_pkg;

    // Opcodes
    localparam logic [7:0] OP_NORMAL_READ          = 8'h03;
    localparam logic [7:0] OP_NORMAL_READ_WIDE     = 8'h13;
    localparam logic [7:0] OP_QUICK_READ           = 8'h0B;
    localparam logic [7:0] OP_QUICK_READ_WIDE      = 8'h0C;
    localparam logic [7:0] OP_DR_QUICK_READ        = 8'h0D;
    localparam logic [7:0] OP_DR_QUICK_READ_WIDE   = 8'h0E;
    localparam logic [7:0] OP_TWO_OUT_READ         = 8'h3B;
    localparam logic [7:0] OP_TWO_OUT_READ_WIDE    = 8'h3C;
    localparam logic [7:0] OP_FOUR_OUT_READ        = 8'h6B;
    localparam logic [7:0] OP_FOUR_OUT_READ_WIDE   = 8'h6C;
    localparam logic [7:0] OP_TWO_AD_READ          = 8'hBB;
    localparam logic [7:0] OP_TWO_AD_READ_WIDE     = 8'hBC;
    localparam logic [7:0] OP_DR_TWO_READ          = 8'hBD;
    localparam logic [7:0] OP_DR_TWO_READ_WIDE     = 8'hBE;
    localparam logic [7:0] OP_FOUR_AD_READ         = 8'hEB;
    localparam logic [7:0] OP_FOUR_AD_READ_WIDE    = 8'hEC;
    localparam logic [7:0] OP_DR_FOUR_READ         = 8'hED;
    localparam logic [7:0] OP_DR_FOUR_READ_WIDE    = 8'hEE;
    localparam logic [7:0] OP_PAGE_PROGRAM         = 8'h02;
    localparam logic [7:0] OP_PAGE_PROGRAM_WIDE    = 8'h12;
    localparam logic [7:0] OP_FOUR_PAGE_PROG_A     = 8'h32;
    localparam logic [7:0] OP_FOUR_PAGE_PROG_B     = 8'h38;
    localparam logic [7:0] OP_FOUR_PAGE_PROG_WIDE  = 8'h34;
    localparam logic [7:0] OP_SECTOR_ERASE         = 8'hD8;
    localparam logic [7:0] OP_SECTOR_ERASE_WIDE    = 8'hDC;
    localparam logic [7:0] OP_ARRAY_ERASE_A        = 8'h60;
    localparam logic [7:0] OP_ARRAY_ERASE_B        = 8'hC7;
    localparam logic [7:0] OP_CLEAR_STATUS         = 8'h30;
    localparam logic [7:0] OP_PARAM_READ           = 8'h5A;
    localparam logic [7:0] OP_LEARN_READ           = 8'h41;
    localparam logic [7:0] OP_LEARN_NV_PROGRAM     = 8'h43;
    localparam logic [7:0] OP_LEARN_VOL_WRITE      = 8'h4A;
    localparam logic [7:0] OP_MAKER_SIG_READ       = 8'h90;
    localparam logic [7:0] OP_IDENT_READ           = 8'h9F;
    localparam logic [7:0] OP_ELEC_SIG_READ        = 8'hAB;
    localparam logic [7:0] OP_BANK_READ            = 8'h16;
    localparam logic [7:0] OP_BANK_WRITE           = 8'h17;
    localparam logic [7:0] OP_BANK_LEGACY          = 8'hB9;
    localparam logic [7:0] OP_RESERVED_A           = 8'hE5;
    localparam logic [7:0] OP_RESERVED_B           = 8'hE6;
    localparam logic [7:0] OP_MULTI_PERF           = 8'hA3;
    localparam logic [7:0] OP_SOFT_RESET           = 8'hF0;
    localparam logic [7:0] OP_MODE_BITS_CLEAR      = 8'hFF;

    // Highest serial clock per command class, MHz
    localparam logic [7:0] MHZ_NORMAL = 8'd50;
    localparam logic [7:0] MHZ_FAST   = 8'd133;
    localparam logic [7:0] MHZ_DDR    = 8'd80;
    localparam logic [7:0] MHZ_MULTI  = 8'd104;

    // Mode bit clear length in serial clocks
    localparam logic [3:0] MBR_CYCLES = 4'd8;

    typedef enum logic [5:0] {
        CMD_NONE                = 6'd0,
        CMD_NORMAL_READ         = 6'd1,
        CMD_NORMAL_READ_WIDE    = 6'd2,
        CMD_QUICK_READ          = 6'd3,
        CMD_QUICK_READ_WIDE     = 6'd4,
        CMD_DR_QUICK_READ       = 6'd5,
        CMD_DR_QUICK_READ_WIDE  = 6'd6,
        CMD_TWO_OUT_READ        = 6'd7,
        CMD_TWO_OUT_READ_WIDE   = 6'd8,
        CMD_FOUR_OUT_READ       = 6'd9,
        CMD_FOUR_OUT_READ_WIDE  = 6'd10,
        CMD_TWO_AD_READ         = 6'd11,
        CMD_TWO_AD_READ_WIDE    = 6'd12,
        CMD_DR_TWO_READ         = 6'd13,
        CMD_DR_TWO_READ_WIDE    = 6'd14,
        CMD_FOUR_AD_READ        = 6'd15,
        CMD_FOUR_AD_READ_WIDE   = 6'd16,
        CMD_DR_FOUR_READ        = 6'd17,
        CMD_DR_FOUR_READ_WIDE   = 6'd18,
        CMD_PAGE_PROGRAM        = 6'd19,
        CMD_PAGE_PROGRAM_WIDE   = 6'd20,
        CMD_FOUR_PAGE_PROG      = 6'd21,
        CMD_FOUR_PAGE_PROG_WIDE = 6'd22,
        CMD_SECTOR_ERASE        = 6'd23,
        CMD_SECTOR_ERASE_WIDE   = 6'd24,
        CMD_ARRAY_ERASE         = 6'd25,
        CMD_CLEAR_STATUS        = 6'd26,
        CMD_PARAM_READ          = 6'd27,
        CMD_LEARN_READ          = 6'd28,
        CMD_LEARN_NV_PROGRAM    = 6'd29,
        CMD_LEARN_VOL_WRITE     = 6'd30,
        CMD_MAKER_SIG_READ      = 6'd31,
        CMD_IDENT_READ          = 6'd32,
        CMD_ELEC_SIG_READ       = 6'd33,
        CMD_BANK_READ           = 6'd34,
        CMD_BANK_WRITE          = 6'd35,
        CMD_SOFT_RESET          = 6'd36,
        CMD_MODE_BITS_CLEAR     = 6'd37
    } sfd_cmd_type;

endpackage

// ---- sfd_link_if.sv ----
`timescale 1ns/10ps
// Serial link between host controller and flash decoder, sampled on i_mclk
interface sfd_link_if;
    logic       cs_n;
    logic       sclk_en;
    logic [3:0] data_line;

    modport host (output cs_n, output sclk_en, output data_line);
    modport dev  (input cs_n, input sclk_en, input data_line);
endinterface

// ---- sfd_device.sv ----
`timescale 1ns/10ps
// Operation
// - 03/13 normal read, 50 MHz limit
// - 0B/0C fast read, 133 MHz limit
// - 0D/0E DDR fast read, 80 MHz
// - 3B/3C dual output read, 104 MHz
// - 6B/6C quad output read, 104 MHz
// - BB/BC dual address-data read, 104 MHz
// - BD/BE DDR dual read, 80 MHz
// - EB/EC quad address-data read, 104 MHz
// - ED/EE DDR quad read, 80 MHz
// - 02/12 page program, 133 MHz limit
// - 32/38/34 quad page program, 80 MHz
// - D8/DC sector erase, 133 MHz limit
// - 60 and C7 both erase array
// - 30 clears erase and program fail
// - 5A parameter table read, 133 MHz
// - 41/43/4A learning pattern commands
// - 90/9F/AB signatures; AB at 50 MHz
// - 16/17/B9 bank register access
// - Host never sends E5, E6, A3
// - Eight ones on line zero exit mode
// - Soft reset keeps freeze, protect lock
module sfd_device
    import sfd_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // Link
    sfd_link_if.dev          link,
    // Decoded command
    output logic             o_cmd_valid,
    output sfd_cmd_type      o_cmd,
    output logic [7:0]       o_max_mhz,
    output logic             o_unknown,
    output logic             o_mode_exit,
    // Retained volatile state
    input  wire logic        i_freeze_set,
    input  wire logic        i_lock_set,
    output logic             o_freeze,
    output logic             o_sector_protect_lock,
    output logic             o_erase_fail,
    output logic             o_program_fail,
    input  wire logic        i_erase_fail_set,
    input  wire logic        i_program_fail_set
);

    logic [7:0]  shift_reg;
    logic [3:0]  bit_cnt_reg;
    logic        ignore_reg;
    logic        busy_reg;
    logic [3:0]  ones_cnt_reg;
    logic        ones_ok_reg;
    sfd_cmd_type dec_cmd;
    logic [7:0]  dec_mhz;

    wire        sel      = ~link.cs_n;
    wire        bit_in   = link.data_line[0];
    wire [7:0]  opcode   = {shift_reg[6:0], bit_in};
    wire        last_bit = sel && link.sclk_en && !busy_reg && !ignore_reg && bit_cnt_reg == 4'd7;
    wire        hit      = last_bit && dec_cmd != CMD_NONE;
    wire        miss     = last_bit && dec_cmd == CMD_NONE;
    wire        soft_rst = hit && dec_cmd == CMD_SOFT_RESET;
    // Only line zero counts; lines one to three are don't care
    wire        ones_done = sel && link.sclk_en && bit_in && ones_ok_reg && ones_cnt_reg == MBR_CYCLES - 4'd1;

    always_comb begin
        dec_cmd = CMD_NONE;
        dec_mhz = MHZ_FAST;
        unique case (opcode)
            OP_NORMAL_READ:         begin dec_cmd = CMD_NORMAL_READ;         dec_mhz = MHZ_NORMAL; end
            OP_NORMAL_READ_WIDE:    begin dec_cmd = CMD_NORMAL_READ_WIDE;    dec_mhz = MHZ_NORMAL; end
            OP_QUICK_READ:          dec_cmd = CMD_QUICK_READ;
            OP_QUICK_READ_WIDE:     dec_cmd = CMD_QUICK_READ_WIDE;
            OP_DR_QUICK_READ:       begin dec_cmd = CMD_DR_QUICK_READ;       dec_mhz = MHZ_DDR; end
            OP_DR_QUICK_READ_WIDE:  begin dec_cmd = CMD_DR_QUICK_READ_WIDE;  dec_mhz = MHZ_DDR; end
            OP_TWO_OUT_READ:        begin dec_cmd = CMD_TWO_OUT_READ;        dec_mhz = MHZ_MULTI; end
            OP_TWO_OUT_READ_WIDE:   begin dec_cmd = CMD_TWO_OUT_READ_WIDE;   dec_mhz = MHZ_MULTI; end
            OP_FOUR_OUT_READ:       begin dec_cmd = CMD_FOUR_OUT_READ;       dec_mhz = MHZ_MULTI; end
            OP_FOUR_OUT_READ_WIDE:  begin dec_cmd = CMD_FOUR_OUT_READ_WIDE;  dec_mhz = MHZ_MULTI; end
            OP_TWO_AD_READ:         begin dec_cmd = CMD_TWO_AD_READ;         dec_mhz = MHZ_MULTI; end
            OP_TWO_AD_READ_WIDE:    begin dec_cmd = CMD_TWO_AD_READ_WIDE;    dec_mhz = MHZ_MULTI; end
            OP_DR_TWO_READ:         begin dec_cmd = CMD_DR_TWO_READ;         dec_mhz = MHZ_DDR; end
            OP_DR_TWO_READ_WIDE:    begin dec_cmd = CMD_DR_TWO_READ_WIDE;    dec_mhz = MHZ_DDR; end
            OP_FOUR_AD_READ:        begin dec_cmd = CMD_FOUR_AD_READ;        dec_mhz = MHZ_MULTI; end
            OP_FOUR_AD_READ_WIDE:   begin dec_cmd = CMD_FOUR_AD_READ_WIDE;   dec_mhz = MHZ_MULTI; end
            OP_DR_FOUR_READ:        begin dec_cmd = CMD_DR_FOUR_READ;        dec_mhz = MHZ_DDR; end
            OP_DR_FOUR_READ_WIDE:   begin dec_cmd = CMD_DR_FOUR_READ_WIDE;   dec_mhz = MHZ_DDR; end
            OP_PAGE_PROGRAM:        dec_cmd = CMD_PAGE_PROGRAM;
            OP_PAGE_PROGRAM_WIDE:   dec_cmd = CMD_PAGE_PROGRAM_WIDE;
            OP_FOUR_PAGE_PROG_A,
            OP_FOUR_PAGE_PROG_B:    begin dec_cmd = CMD_FOUR_PAGE_PROG;      dec_mhz = MHZ_DDR; end
            OP_FOUR_PAGE_PROG_WIDE: begin dec_cmd = CMD_FOUR_PAGE_PROG_WIDE; dec_mhz = MHZ_DDR; end
            OP_SECTOR_ERASE:        dec_cmd = CMD_SECTOR_ERASE;
            OP_SECTOR_ERASE_WIDE:   dec_cmd = CMD_SECTOR_ERASE_WIDE;
            OP_ARRAY_ERASE_A,
            OP_ARRAY_ERASE_B:       dec_cmd = CMD_ARRAY_ERASE;
            OP_CLEAR_STATUS:        dec_cmd = CMD_CLEAR_STATUS;
            OP_PARAM_READ:          dec_cmd = CMD_PARAM_READ;
            OP_LEARN_READ:          dec_cmd = CMD_LEARN_READ;
            OP_LEARN_NV_PROGRAM:    dec_cmd = CMD_LEARN_NV_PROGRAM;
            OP_LEARN_VOL_WRITE:     dec_cmd = CMD_LEARN_VOL_WRITE;
            OP_MAKER_SIG_READ:      dec_cmd = CMD_MAKER_SIG_READ;
            OP_IDENT_READ:          dec_cmd = CMD_IDENT_READ;
            OP_ELEC_SIG_READ:       begin dec_cmd = CMD_ELEC_SIG_READ;       dec_mhz = MHZ_NORMAL; end
            OP_BANK_READ:           dec_cmd = CMD_BANK_READ;
            OP_BANK_WRITE,
            OP_BANK_LEGACY:         dec_cmd = CMD_BANK_WRITE;
            OP_SOFT_RESET:          dec_cmd = CMD_SOFT_RESET;
            OP_MODE_BITS_CLEAR:     dec_cmd = CMD_MODE_BITS_CLEAR;
            default:                dec_cmd = CMD_NONE;
        endcase
    end

    // Opcode shifter; after a decode the rest of the frame is payload
    always_ff @(posedge i_mclk) begin
        if (i_rst || !sel) begin
            shift_reg   <= 8'h00;
            bit_cnt_reg <= 4'd0;
            busy_reg    <= 1'b0;
            ignore_reg  <= 1'b0;
        end else if (link.sclk_en && !busy_reg && !ignore_reg) begin
            shift_reg   <= opcode;
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
            busy_reg    <= hit;
            ignore_reg  <= miss;
        end
    end

    // Count ones on line zero from the frame start
    always_ff @(posedge i_mclk) begin
        if (i_rst || !sel) begin
            ones_cnt_reg <= 4'd0;
            ones_ok_reg  <= 1'b1;
        end else if (link.sclk_en && ones_ok_reg) begin
            ones_cnt_reg <= ones_cnt_reg + 4'd1;
            ones_ok_reg  <= bit_in && ones_cnt_reg < MBR_CYCLES - 4'd1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_cmd_valid <= 1'b0;
            o_cmd       <= CMD_NONE;
            o_max_mhz   <= 8'h00;
            o_unknown   <= 1'b0;
            o_mode_exit <= 1'b0;
        end else begin
            o_cmd_valid <= hit;
            o_unknown   <= miss;
            o_mode_exit <= ones_done;
            if (hit) begin
                o_cmd     <= dec_cmd;
                o_max_mhz <= dec_mhz;
            end
        end
    end

    // Soft reset clears fail flags but not freeze or lock; set beats clear
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_freeze              <= 1'b0;
            o_sector_protect_lock <= 1'b0;
            o_erase_fail          <= 1'b0;
            o_program_fail        <= 1'b0;
        end else begin
            o_freeze              <= o_freeze | i_freeze_set;
            o_sector_protect_lock <= o_sector_protect_lock | i_lock_set;
            if (i_erase_fail_set)
                o_erase_fail <= 1'b1;
            else if (soft_rst || (hit && dec_cmd == CMD_CLEAR_STATUS))
                o_erase_fail <= 1'b0;
            if (i_program_fail_set)
                o_program_fail <= 1'b1;
            else if (soft_rst || (hit && dec_cmd == CMD_CLEAR_STATUS))
                o_program_fail <= 1'b0;
        end
    end

endmodule

// ---- sfd_host.sv ----
`timescale 1ns/10ps
module sfd_host
    import sfd_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // Link
    sfd_link_if.host         link,
    // User request
    input  wire logic        i_start,
    input  wire logic [7:0]  i_opcode,
    input  wire logic [7:0]  i_payload_bits,
    input  wire logic [7:0]  i_link_mhz,
    output logic             o_busy,
    output logic             o_refused
);

    logic [7:0]  sh_reg;
    logic [8:0]  cnt_reg;
    logic        ok_mhz;
    wire  [8:0]  total = 9'd8 + {1'b0, i_payload_bits};

    // Reserved codes are never sent
    wire reserved = i_opcode == OP_RESERVED_A || i_opcode == OP_RESERVED_B || i_opcode == OP_MULTI_PERF;

    // Refuse when the link rate is above the command's limit
    always_comb begin
        unique case (i_opcode)
            OP_NORMAL_READ, OP_NORMAL_READ_WIDE, OP_ELEC_SIG_READ:
                ok_mhz = i_link_mhz <= MHZ_NORMAL;
            OP_DR_QUICK_READ, OP_DR_QUICK_READ_WIDE, OP_DR_TWO_READ, OP_DR_TWO_READ_WIDE,
            OP_DR_FOUR_READ, OP_DR_FOUR_READ_WIDE, OP_FOUR_PAGE_PROG_A, OP_FOUR_PAGE_PROG_B,
            OP_FOUR_PAGE_PROG_WIDE:
                ok_mhz = i_link_mhz <= MHZ_DDR;
            OP_TWO_OUT_READ, OP_TWO_OUT_READ_WIDE, OP_FOUR_OUT_READ, OP_FOUR_OUT_READ_WIDE,
            OP_TWO_AD_READ, OP_TWO_AD_READ_WIDE, OP_FOUR_AD_READ, OP_FOUR_AD_READ_WIDE:
                ok_mhz = i_link_mhz <= MHZ_MULTI;
            default:
                ok_mhz = i_link_mhz <= MHZ_FAST;
        endcase
    end

    wire accept = i_start && !o_busy && !reserved && ok_mhz;

    // Mode bit clear (FF) drives eight ones on line zero, then its i_payload_bits payload bits as zeros
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_busy         <= 1'b0;
            o_refused      <= 1'b0;
            sh_reg         <= 8'h00;
            cnt_reg        <= 9'd0;
            link.cs_n      <= 1'b1;
            link.sclk_en   <= 1'b0;
            link.data_line <= 4'h0;
        end else begin
            o_refused <= i_start && !o_busy && !accept;
            if (accept) begin
                o_busy         <= 1'b1;
                link.cs_n      <= 1'b0;
                link.sclk_en   <= 1'b1;
                link.data_line <= {3'b000, i_opcode[7]};
                sh_reg         <= {i_opcode[6:0], 1'b0};
                cnt_reg        <= total - 9'd1;
            end else if (o_busy && cnt_reg != 9'd0) begin
                link.data_line <= {3'b000, sh_reg[7]};
                sh_reg         <= {sh_reg[6:0], 1'b0};
                cnt_reg        <= cnt_reg - 9'd1;
            end else if (o_busy) begin
                o_busy         <= 1'b0;
                link.cs_n      <= 1'b1;
                link.sclk_en   <= 1'b0;
                link.data_line <= 4'h0;
            end
        end
    end

endmodule

// ---- sfd_assertions.sv ----
`timescale 1ns/10ps
module sfd_assertions
    import sfd_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // Link
    input  wire logic        cs_n,
    input  wire logic        sclk_en,
    input  wire logic [3:0]  data_line,
    // Decoder outputs
    input  wire logic        o_cmd_valid,
    input  wire sfd_cmd_type o_cmd,
    input  wire logic [7:0]  o_max_mhz,
    input  wire logic        o_mode_exit,
    input  wire logic        o_unknown
);
    logic [7:0] op_reg;
    logic [3:0] cnt_reg;

    // Only the first eight bits of a frame form the opcode; payload bits are not shifted in
    always_ff @(posedge i_mclk) begin
        if (i_rst || cs_n) begin
            cnt_reg <= 4'h0;
        end else if (sclk_en && cnt_reg < 4'h8) begin
            op_reg  <= {op_reg[6:0], data_line[0]};
            cnt_reg <= cnt_reg + 4'h1;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    sequence bit_run;
        (!cs_n && sclk_en) [*8];
    endsequence
    sequence answer;
        o_cmd_valid || o_unknown;
    endsequence

    frame_idle_a:     assert property (cs_n |-> !sclk_en) else $error("clock runs outside a frame");
    decode_timing_a:  assert property ($fell(cs_n) |-> bit_run ##1 answer)
        else $error("no decode after 8 bits");
    normal_rate_a:    assert property (o_cmd_valid && (op_reg == 8'h03 || op_reg == 8'h13) |->
        (o_cmd == CMD_NORMAL_READ || o_cmd == CMD_NORMAL_READ_WIDE) && o_max_mhz == 8'd50) else $error("normal read");
    fast_rate_a:      assert property (o_cmd_valid && (op_reg == 8'h0B || op_reg == 8'h0C) |->
        o_max_mhz == 8'd133) else $error("fast read rate");
    ddr_rate_a:       assert property (o_cmd_valid && op_reg inside {8'h0D, 8'h0E,
        8'hBD, 8'hBE, 8'hED, 8'hEE} |-> o_max_mhz == 8'd80) else $error("double rate limit");
    multi_rate_a:     assert property (o_cmd_valid && op_reg inside {8'h3B, 8'h3C,
        8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hEB, 8'hEC} |-> o_max_mhz == 8'd104) else $error("multi-line limit");
    array_erase_a:    assert property (o_cmd_valid && (op_reg == 8'h60 || op_reg == 8'hC7) |->
        o_cmd == CMD_ARRAY_ERASE) else $error("array erase alias");
    bank_legacy_a:    assert property (o_cmd_valid && op_reg == 8'hB9 |-> o_cmd == CMD_BANK_WRITE)
        else $error("legacy bank access");
    mode_exit_a:      assert property (o_mode_exit |-> op_reg == 8'hFF && $past(cnt_reg) == 4'h7)
        else $error("mode exit without eight ones");
endmodule

// ---- serial_flash_opcode_decoder_tb_top.sv ----
`timescale 1ns/10ps
module serial_flash_opcode_decoder_tb_top
    import sfd_pkg::*;
;
    typedef struct packed {logic [7:0] op; sfd_cmd_type cmd; logic [7:0] mhz;} sfd_ent_type;
    localparam logic [7:0] mn = MHZ_NORMAL;
    localparam logic [7:0] mf = MHZ_FAST;
    localparam logic [7:0] md = MHZ_DDR;
    localparam logic [7:0] mm = MHZ_MULTI;
    logic i_mclk, i_rst, i_start, i_freeze_set, i_lock_set, i_erase_fail_set, i_program_fail_set;
    logic [7:0] i_opcode, i_payload_bits, i_link_mhz;
    logic o_busy, o_refused, o_cmd_valid, o_unknown, o_mode_exit, o_freeze, o_lock, o_erase_fail, o_program_fail;
    logic b_valid, b_unk, b_mode;
    sfd_cmd_type o_cmd, b_cmd;
    logic [7:0] o_max_mhz, b_mhz;
    logic [15:0] q[$];
    sfd_ent_type tbl[$];
    int bad_count, cmp_count;
    sfd_link_if lk();
    sfd_link_if lk2();

    sfd_host u_sfd_host (.i_mclk(i_mclk), .i_rst(i_rst), .link(lk), .i_start(i_start), .i_opcode(i_opcode),
        .i_payload_bits(i_payload_bits), .i_link_mhz(i_link_mhz), .o_busy(o_busy), .o_refused(o_refused));
    sfd_device u_sfd_device (.i_mclk(i_mclk), .i_rst(i_rst), .link(lk), .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd),
        .o_max_mhz(o_max_mhz), .o_unknown(o_unknown), .o_mode_exit(o_mode_exit), .i_freeze_set(i_freeze_set),
        .i_lock_set(i_lock_set), .o_freeze(o_freeze), .o_sector_protect_lock(o_lock), .o_erase_fail(o_erase_fail),
        .o_program_fail(o_program_fail), .i_erase_fail_set(i_erase_fail_set), .i_program_fail_set(i_program_fail_set));
    // Second device faces the bench directly so frames the host refuses can still be sent
    sfd_device u_sfd_device_b (.i_mclk(i_mclk), .i_rst(i_rst), .link(lk2), .o_cmd_valid(b_valid), .o_cmd(b_cmd),
        .o_max_mhz(b_mhz), .o_unknown(b_unk), .o_mode_exit(b_mode), .i_freeze_set(i_freeze_set),
        .i_lock_set(i_lock_set), .o_freeze(), .o_sector_protect_lock(), .o_erase_fail(), .o_program_fail(),
        .i_erase_fail_set(i_erase_fail_set), .i_program_fail_set(i_program_fail_set));
    sfd_assertions u_sfd_assertions (.i_mclk(i_mclk), .i_rst(i_rst), .cs_n(lk.cs_n), .sclk_en(lk.sclk_en),
        .data_line(lk.data_line), .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .o_max_mhz(o_max_mhz),
        .o_mode_exit(o_mode_exit), .o_unknown(o_unknown));

    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Mismatches %0d, comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Any result without a pending note is compared against an impossible value
    task automatic take(input logic [15:0] seen);
        if (q.size() == 0) check(seen, 16'hFFFF);
        else check(seen, q.pop_front());
    endtask

    always @(posedge i_mclk) begin
        if (!i_rst) begin
            if (o_mode_exit === 1'b1 || b_mode === 1'b1) take(16'h0000);
            if (o_cmd_valid === 1'b1) take({2'd1, o_cmd, o_max_mhz});
            if (b_valid === 1'b1) take({2'd1, b_cmd, b_mhz});
            if (o_refused === 1'b1) take({2'd2, 14'h0000});
            if (o_unknown === 1'b1 || b_unk === 1'b1) take({2'd3, 14'h0000});
        end
    end

    task automatic send(input logic [7:0] op, input logic [7:0] mhz);
        int n;
        i_start        <= 1'b1;
        i_opcode       <= op;
        i_payload_bits <= 8'($urandom_range(7, 0));
        i_link_mhz     <= mhz;
        @(posedge i_mclk);
        i_start <= 1'b0;
        repeat (2) @(posedge i_mclk);
        n = 0;
        while (o_busy === 1'b1 && n < 300) begin
            @(posedge i_mclk);
            n++;
        end
        if (n >= 300) begin
            bad_count++;
            stop_test();
        end
        repeat (3) @(posedge i_mclk);
    endtask

    // Upper data lines carry noise: the device must look at line zero only
    task automatic raw(input logic [15:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            lk2.cs_n      <= 1'b0;
            lk2.sclk_en   <= 1'b1;
            lk2.data_line <= {3'($urandom), bits[i]};
            @(posedge i_mclk);
        end
        lk2.cs_n      <= 1'b1;
        lk2.sclk_en   <= 1'b0;
        lk2.data_line <= 4'($urandom);
        repeat (3) @(posedge i_mclk);
    endtask

    task automatic pulse_sets();
        i_erase_fail_set   <= 1'b1;
        i_program_fail_set <= 1'b1;
        i_freeze_set       <= 1'b1;
        i_lock_set         <= 1'b1;
        @(posedge i_mclk);
        {i_erase_fail_set, i_program_fail_set, i_freeze_set, i_lock_set} <= 4'h0;
        repeat (2) @(posedge i_mclk);
    endtask

    initial begin
        repeat (100000) @(posedge i_mclk);
        bad_count++;
        stop_test();
    end

    initial begin
        {i_rst, i_start, i_freeze_set, i_lock_set, i_erase_fail_set, i_program_fail_set} = 6'h20;
        {i_opcode, i_payload_bits, i_link_mhz} = 24'h0000_00;
        {lk2.cs_n, lk2.sclk_en, lk2.data_line} = 6'h20;
        void'($urandom(32'hbbf8));
        tbl = '{'{8'h03, CMD_NORMAL_READ, mn}, '{8'h13, CMD_NORMAL_READ_WIDE, mn},
            '{8'h0B, CMD_QUICK_READ, mf}, '{8'h0C, CMD_QUICK_READ_WIDE, mf},
            '{8'h0D, CMD_DR_QUICK_READ, md}, '{8'h0E, CMD_DR_QUICK_READ_WIDE, md},
            '{8'h3B, CMD_TWO_OUT_READ, mm}, '{8'h3C, CMD_TWO_OUT_READ_WIDE, mm},
            '{8'h6B, CMD_FOUR_OUT_READ, mm}, '{8'h6C, CMD_FOUR_OUT_READ_WIDE, mm},
            '{8'hBB, CMD_TWO_AD_READ, mm}, '{8'hBC, CMD_TWO_AD_READ_WIDE, mm},
            '{8'hBD, CMD_DR_TWO_READ, md}, '{8'hBE, CMD_DR_TWO_READ_WIDE, md},
            '{8'hEB, CMD_FOUR_AD_READ, mm}, '{8'hEC, CMD_FOUR_AD_READ_WIDE, mm},
            '{8'hED, CMD_DR_FOUR_READ, md}, '{8'hEE, CMD_DR_FOUR_READ_WIDE, md},
            '{8'h02, CMD_PAGE_PROGRAM, mf}, '{8'h12, CMD_PAGE_PROGRAM_WIDE, mf},
            '{8'h32, CMD_FOUR_PAGE_PROG, md}, '{8'h38, CMD_FOUR_PAGE_PROG, md},
            '{8'h34, CMD_FOUR_PAGE_PROG_WIDE, md}, '{8'hD8, CMD_SECTOR_ERASE, mf},
            '{8'hDC, CMD_SECTOR_ERASE_WIDE, mf}, '{8'h60, CMD_ARRAY_ERASE, mf},
            '{8'hC7, CMD_ARRAY_ERASE, mf}, '{8'h30, CMD_CLEAR_STATUS, mf}, '{8'h5A, CMD_PARAM_READ, mf},
            '{8'h41, CMD_LEARN_READ, mf}, '{8'h43, CMD_LEARN_NV_PROGRAM, mf},
            '{8'h4A, CMD_LEARN_VOL_WRITE, mf}, '{8'h90, CMD_MAKER_SIG_READ, mf},
            '{8'h9F, CMD_IDENT_READ, mf}, '{8'hAB, CMD_ELEC_SIG_READ, mn}, '{8'h16, CMD_BANK_READ, mf},
            '{8'h17, CMD_BANK_WRITE, mf}, '{8'hB9, CMD_BANK_WRITE, mf}, '{8'hF0, CMD_SOFT_RESET, mf},
            '{8'hFF, CMD_MODE_BITS_CLEAR, mf}};
        repeat (16) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        foreach (tbl[i]) begin
            if (tbl[i].op == 8'hFF) q.push_back(16'h0000);
            q.push_back({2'd1, tbl[i].cmd, tbl[i].mhz});
            send(tbl[i].op, tbl[i].mhz);
            q.push_back({2'd2, 14'h0000});
            send(tbl[i].op, tbl[i].mhz + 8'd1);
        end
        for (int i = 0; i < 3; i++) begin
            q.push_back({2'd2, 14'h0000});
            send(i == 0 ? 8'hE5 : i == 1 ? 8'hE6 : 8'hA3, 8'd50);
        end
        pulse_sets();
        check(16'(o_erase_fail), 16'h0001);
        q.push_back({2'd1, CMD_SOFT_RESET, mf});
        send(OP_SOFT_RESET, mf);
        check(16'({o_freeze, o_lock, o_erase_fail, o_program_fail}), 16'h000C);
        pulse_sets();
        q.push_back({2'd1, CMD_CLEAR_STATUS, mf});
        send(OP_CLEAR_STATUS, mf);
        check(16'({o_erase_fail, o_program_fail}), 16'h0000);
        for (int i = 0; i < 4; i++) begin
            q.push_back({2'd3, 14'h0000});
            raw({i == 0 ? 8'hE5 : i == 1 ? 8'hE6 : i == 2 ? 8'hA3 : 8'h01, 8'hFF}, 16);
        end
        q.push_back({2'd1, CMD_CLEAR_STATUS, mf});
        raw({8'h30, 8'hFF}, 16);
        q.push_back(16'h0000);
        q.push_back({2'd1, CMD_MODE_BITS_CLEAR, mf});
        raw(16'h00FF, 8);
        check(16'(q.size()), 16'h0000);
        stop_test();
    end
endmodule
